/* shared/sci_consts.vh */
// Functional notes
// (RL1) frame: start, 8/9 data, one stop
// (RL2) data shifted least significant bit first
// (RL3) idle high, start low, stop high
// (RL4) break is full frame of zeros
// (RL5) shift clock only on data bits
// (RL6) data write starts transmission on bit clock
// (RL7) buffer move sets tx_buffer_empty, interrupt
// (RL8) shifting done, nothing pending: tx_done_flag
// (RL9) disabled and drained also sets tx_done_flag
// (RL10) disable mid-character finishes that character
// (RL11) received byte moved, rx_buffer_full, interrupt
// (RL12) overrun, noise and framing error flags
// (RL13) idle flag with enable requests interrupt
// (RL14) idle needs a prior valid character
// (RL15) prescaler ahead of separate rate selectors
// (RL16) fixed divide-by-16 ahead of transmitter
// (RL17) software changes rates only when disabled; the rate register here accepts writes at any time
// (RL18) control registers hold listed control bits
// (RL19) rx_sleep inhibits all receiver status flags
// (RL20) idle detection suppressed while sleeping
// (RL21) wake condition clears rx_sleep in hardware
// (RL22) transmitter and receiver run independently
// (RL23) idle wake after a frame of ones
// (RL24) address-mark wake on character msb set
// (RL25) sixteen-fold sampling, majority of 8,9,10
// (RL26) start verified by three samples, noise
// (RL27) break sent in whole frame units
// (RL28) preamble idle frame after enabling
`ifndef SCI_CONSTS_VH
`define SCI_CONSTS_VH
// register byte offsets
`define SCI_OFS_DATA 8'h00
`define SCI_OFS_CTL1 8'h04
`define SCI_OFS_CTL2 8'h08
`define SCI_OFS_FLAG 8'h0C
`define SCI_OFS_RATE 8'h10
// serial_ctl_one fields
`define SCI_C1_RX8 7
`define SCI_C1_TX8 6
`define SCI_C1_NINE 4
`define SCI_C1_WAKE 3
`define SCI_C1_CPOL 2
`define SCI_C1_CPHA 1
`define SCI_C1_LAST 0
// serial_ctl_two fields
`define SCI_C2_TXIE 7
`define SCI_C2_TX_DONE_IRQ_EN 6
`define SCI_C2_RXIE 5
`define SCI_C2_ILIE 4
`define SCI_C2_TXON 3
`define SCI_C2_RXON 2
`define SCI_C2_SLEEP 1
`define SCI_C2_BRK 0
// serial_flags_reg fields
`define SCI_F_TX_BUFFER_EMPTY 7
`define SCI_F_TC 6
`define SCI_F_RBF 5
`define SCI_F_IDLE 4
`define SCI_F_OVR 3
`define SCI_F_NOISE 2
`define SCI_F_FRM 1
// reset values
`define SCI_RST_CTL 8'h00
`define SCI_RST_RATE 8'h00
// timing: receive oversampling and sample positions (zero based)
`define SCI_OVERSAMPLE 4'hF
`define SCI_SMP_A 4'h7
`define SCI_SMP_B 4'h8
`define SCI_SMP_C 4'h9
`define SCI_VER_A 4'h2
`define SCI_VER_B 4'h4
`define SCI_VER_C 4'h6
// frame lengths in bits
`define SCI_FRAME8 4'hA
`define SCI_FRAME9 4'hB
`endif

/* core/sci_top.v */
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sci_consts.vh"
module sci_top (
	input wire aclk, // bus clock, 250 MHz
	input wire aresetn, // synchronous reset, active low
	input wire [7:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output reg s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write byte strobes
	input wire s_axi_wvalid, // write data valid
	output reg s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [7:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output reg s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire rx_line, // serial receive pin
	output reg tx_line, // serial transmit pin
	output reg tx_line_oe, // transmit pin drive enable
	output reg sclk_o, // synchronous shift clock pin
	output reg sclk_oe, // shift clock drive enable
	output reg sci_irq // combined interrupt request
);
	// one-hot state codes
	localparam [3:0] TX_IDLE = 4'b0001;
	localparam [3:0] TX_PRE = 4'b0010;
	localparam [3:0] TX_BRK = 4'b0100;
	localparam [3:0] TX_DATA = 4'b1000;
	localparam [2:0] RX_IDLE = 3'b001;
	localparam [2:0] RX_VER = 3'b010;
	localparam [2:0] RX_BITS = 3'b100;

	// tick when the low sel bits of the chain are all ones
	function sel_tick;
		input [7:0] chain;
		input [2:0] sel;
		reg [7:0] mask;
		begin
			mask = (8'h01 << sel) - 8'h01;
			sel_tick = ((chain & mask) == mask);
		end
	endfunction

	// majority of three samples
	function maj3;
		input [2:0] s;
		begin
			maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
		end
	endfunction

	// software state
	reg [7:0] ctl1_r; // serial_ctl_one
	reg [7:0] ctl2_r; // serial_ctl_two
	reg [7:0] rate_r; // prescale, tx and rx rate selects
	reg [7:0] tdr_r; // transmit holding byte
	reg [7:0] rdr_r; // received byte
	reg rx8_r; // received ninth bit
	reg tx_buffer_empty_r, tc_r, rbf_r, idle_r, ovr_r, nf_r, fe_r; // status flags
	// bus slave bookkeeping
	reg aw_got_r, w_got_r; // address or data held
	reg [7:0] awaddr_q_r; // held write address
	reg [7:0] wdata_q_r; // held write byte
	reg wlane_q_r; // low byte lane enabled
	// rate generation
	reg [2:0] pcnt_r; // prescale counter
	reg [7:0] chain_r; // divider chain after prescaler
	reg [3:0] tx16_r; // fixed divide-by-16 for transmitter
	// transmitter
	reg [3:0] tx_st_r; // transmitter state
	reg [10:0] txsh_r; // transmit shift register
	reg [3:0] txcnt_r; // bits left in current frame
	reg [3:0] txidx_r; // index of bit on the line
	reg pre_pend_r; // preamble owed after enabling
	reg txon_d_r; // tx_on delayed, for enable edge
	// receiver
	reg rxs1_r, rxs2_r; // input synchroniser
	reg rx_prev_r; // line at previous sample tick
	reg [2:0] rx_st_r; // receiver state
	reg [3:0] rt_r; // sample tick inside bit
	reg [3:0] ridx_r; // bit index in frame
	reg [2:0] smp_r; // sample shift register
	reg [1:0] vz_r; // zero count of verify samples
	reg [8:0] rxsh_r; // receive shift register
	reg rnz_r; // noise seen in this frame
	reg got_char_r; // valid character since last idle
	reg [7:0] idle_cnt_r; // ticks of continuous high

	wire nine = ctl1_r[`SCI_C1_NINE];
	wire tx_on = ctl2_r[`SCI_C2_TXON];
	wire rx_on = ctl2_r[`SCI_C2_RXON];
	wire sleep = ctl2_r[`SCI_C2_SLEEP];
	wire [3:0] nbits = nine ? `SCI_FRAME9 : `SCI_FRAME8;

	// bus handshake terms
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire do_wr = aw_got_r & w_got_r & ~s_axi_bvalid;
	wire aw_got_nxt = aw_got_r ? ~do_wr : aw_hs;
	wire w_got_nxt = w_got_r ? ~do_wr : w_hs;
	wire bvalid_nxt = do_wr | (s_axi_bvalid & ~s_axi_bready);
	wire rvalid_nxt = ar_hs | (s_axi_rvalid & ~s_axi_rready);
	wire wr_en = do_wr & wlane_q_r;
	wire wr_data = wr_en & (awaddr_q_r == `SCI_OFS_DATA);
	wire wr_flag = wr_en & (awaddr_q_r == `SCI_OFS_FLAG);
	wire rd_data = ar_hs & (s_axi_araddr == `SCI_OFS_DATA);

	// AXI4-Lite write channel: address and data in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			awaddr_q_r <= 8'h00;
			wdata_q_r <= 8'h00;
			wlane_q_r <= 1'b0;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			// ready reopens only after the response is taken
			s_axi_awready <= ~aw_got_nxt & ~bvalid_nxt;
			s_axi_wready <= ~w_got_nxt & ~bvalid_nxt;
			s_axi_bvalid <= bvalid_nxt;
			if (aw_hs) begin
				awaddr_q_r <= s_axi_awaddr;
			end
			if (w_hs) begin
				wdata_q_r <= s_axi_wdata[7:0];
				wlane_q_r <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				// unmapped offsets answer with slave error
				s_axi_bresp <= (awaddr_q_r > `SCI_OFS_RATE ||
					awaddr_q_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end
		end
	end

	// AXI4-Lite read channel: data one cycle after address
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= ~rvalid_nxt;
			s_axi_rvalid <= rvalid_nxt;
			if (ar_hs) begin
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
				`SCI_OFS_DATA: s_axi_rdata <= {24'h000000, rdr_r};
				`SCI_OFS_CTL1: s_axi_rdata <= {24'h000000, rx8_r,
					ctl1_r[6:0]};
				`SCI_OFS_CTL2: s_axi_rdata <= {24'h000000, ctl2_r};
				`SCI_OFS_FLAG: s_axi_rdata <= {24'h000000, tx_buffer_empty_r, tc_r,
					rbf_r, idle_r, ovr_r, nf_r, fe_r, 1'b0};
				`SCI_OFS_RATE: s_axi_rdata <= {24'h000000, rate_r};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end
		end
	end

	// rate generator: prescaler, then shared chain of dividers
	wire [2:0] pdiv = (3'h1 << rate_r[7:6]) - 3'h1;
	wire pre_tick = (pcnt_r >= pdiv);
	// (RL15) separate rate taps
	wire rx_tick = pre_tick & sel_tick(chain_r, rate_r[2:0]);
	wire tx_tick = pre_tick & sel_tick(chain_r, rate_r[5:3]);
	// (RL16) divide by sixteen
	wire tx_bit = tx_tick & (tx16_r == `SCI_OVERSAMPLE);
	always @(posedge aclk) begin
		if (!aresetn) begin
			pcnt_r <= 3'h0;
			chain_r <= 8'h00;
			tx16_r <= 4'h0;
		end else begin
			pcnt_r <= pre_tick ? 3'h0 : pcnt_r + 3'h1;
			if (pre_tick) begin
				chain_r <= chain_r + 8'h01;
			end
			if (tx_tick) begin
				tx16_r <= tx16_r + 4'h1;
			end
		end
	end

	// transmitter: next frame chosen at the end of a frame, or at any bit boundary while idle
	wire tx_fin = tx_bit & ((tx_st_r == TX_IDLE) || (txcnt_r == 4'h1));
	wire ld_brk = tx_fin & tx_on & ctl2_r[`SCI_C2_BRK];
	wire ld_pre = tx_fin & tx_on & ~ld_brk & pre_pend_r;
	wire ld_dat = tx_fin & tx_on & ~ld_brk & ~pre_pend_r & ~tx_buffer_empty_r;
	wire tx_end = tx_fin & ~ld_brk & ~ld_pre & ~ld_dat &
		(tx_st_r != TX_IDLE);
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_st_r <= TX_IDLE;
			txsh_r <= 11'h7FF;
			txcnt_r <= 4'h0;
			txidx_r <= 4'h0;
			pre_pend_r <= 1'b0;
			txon_d_r <= 1'b0;
		end else begin
			txon_d_r <= tx_on;
			// (RL28) preamble owed
			if (tx_on & ~txon_d_r) begin
				pre_pend_r <= 1'b1;
			end else if (ld_pre) begin
				pre_pend_r <= 1'b0;
			end
			txidx_r <= tx_fin ? 4'h0 : (tx_bit ? txidx_r + 4'h1 : txidx_r);
			if (tx_fin) begin
				txcnt_r <= nbits;
				case (1'b1)
				// (RL27) whole break frames
				ld_brk: begin
					tx_st_r <= TX_BRK;
					txsh_r <= 11'h000;
				end
				// (RL3) ones frame
				ld_pre: begin
					tx_st_r <= TX_PRE;
					txsh_r <= 11'h7FF;
				end
				// (RL1) start, data, stop
				ld_dat: begin
					tx_st_r <= TX_DATA;
					txsh_r <= {1'b1, nine ? ctl1_r[`SCI_C1_TX8] : 1'b1,
						tdr_r, 1'b0};
				end
				// (RL10) only stops between frames
				default: begin
					tx_st_r <= TX_IDLE;
					txsh_r <= 11'h7FF;
				end
				endcase
			end else if (tx_bit) begin
				// (RL2) lsb leaves first
				txsh_r <= {1'b1, txsh_r[10:1]};
				txcnt_r <= txcnt_r - 4'h1;
			end
		end
	end

	// pins: line follows shift register; clock only on data bits
	wire tx_busy = (tx_st_r != TX_IDLE);
	wire [3:0] last_dat = nbits - 4'h2;
	wire sclk_act = (tx_st_r == TX_DATA) && (txidx_r != 4'h0) &&
		((txidx_r < last_dat) ||
		(txidx_r == last_dat && ctl1_r[`SCI_C1_LAST]));
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_line <= 1'b1;
			tx_line_oe <= 1'b0;
			sclk_o <= 1'b0;
			sclk_oe <= 1'b0;
		end else begin
			tx_line <= tx_busy ? txsh_r[0] : 1'b1;
			tx_line_oe <= tx_on | tx_busy;
			sclk_oe <= tx_on | tx_busy;
			// (RL5) data-bit clock
			sclk_o <= ctl1_r[`SCI_C1_CPOL] ^ (sclk_act &
				(tx16_r[3] ^ ctl1_r[`SCI_C1_CPHA]));
		end
	end

	// receiver input synchroniser
	always @(posedge aclk) begin
		if (!aresetn) begin
			rxs1_r <= 1'b1;
			rxs2_r <= 1'b1;
		end else begin
			rxs1_r <= rx_line;
			rxs2_r <= rxs1_r;
		end
	end

	// receiver decisions at sample tick nine of a bit
	wire [2:0] smp_now = {rxs2_r, smp_r[1:0]};
	wire vote = maj3(smp_now);
	wire bit_nz = ~(&smp_now) & (|smp_now);
	wire at_vote = rx_tick & (rx_st_r == RX_BITS) & (rt_r == `SCI_SMP_C);
	wire fr_end = at_vote & (ridx_r == nbits - 4'h1);
	wire [7:0] rx_byte = nine ? rxsh_r[7:0] : rxsh_r[8:1];
	wire rx_msb = rxsh_r[8];
	// (RL24) address-mark wake
	wire wake_adr = fr_end & sleep & ctl1_r[`SCI_C1_WAKE] & rx_msb;
	wire rx_live = fr_end & ~sleep | wake_adr;
	wire [7:0] idle_lim = {nbits, 4'h0} - 8'h01;
	wire idle_evt = rx_tick & rx_on & rxs2_r & (idle_cnt_r == idle_lim);
	// (RL23) idle-line wake
	wire wake_idl = idle_evt & sleep & ~ctl1_r[`SCI_C1_WAKE];
	// (RL20) no idle detect asleep
	wire idle_set = idle_evt & ~sleep & got_char_r;

	// receiver state machine
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_st_r <= RX_IDLE;
			rt_r <= 4'h0;
			ridx_r <= 4'h0;
			smp_r <= 3'h7;
			vz_r <= 2'h0;
			rxsh_r <= 9'h000;
			rnz_r <= 1'b0;
			rx_prev_r <= 1'b1;
			idle_cnt_r <= 8'h00;
		end else if (!rx_on) begin
			rx_st_r <= RX_IDLE;
			rx_prev_r <= 1'b1;
			idle_cnt_r <= 8'h00;
		end else if (rx_tick) begin
			rx_prev_r <= rxs2_r;
			// count continuous high, saturating at one frame
			if (!rxs2_r) begin
				idle_cnt_r <= 8'h00;
			end else if (idle_cnt_r != idle_lim + 8'h01) begin
				idle_cnt_r <= idle_cnt_r + 8'h01;
			end
			rt_r <= rt_r + 4'h1;
			case (rx_st_r)
			RX_IDLE: begin
				// falling edge needs a high first, so a break
				// holds off the next start until the line rises
				if (rx_prev_r & ~rxs2_r) begin
					rx_st_r <= RX_VER;
					rt_r <= 4'h1;
					vz_r <= 2'h0;
					rnz_r <= 1'b0;
					ridx_r <= 4'h0;
				end
			end
			RX_VER: begin
				// (RL26) verification samples
				if (rt_r == `SCI_VER_A || rt_r == `SCI_VER_B ||
					rt_r == `SCI_VER_C) begin
					if (!rxs2_r) begin
						vz_r <= vz_r + 2'h1;
					end else begin
						rnz_r <= 1'b1;
					end
				end
				if (rt_r == `SCI_VER_C) begin
					rx_st_r <= (vz_r + {1'b0, ~rxs2_r} >= 2'h2) ?
						RX_BITS : RX_IDLE;
				end
			end
			RX_BITS: begin
				// (RL25) three samples, majority
				if (rt_r == `SCI_SMP_A || rt_r == `SCI_SMP_B) begin
					smp_r <= {smp_r[1:0], rxs2_r};
				end
				if (rt_r == `SCI_SMP_C) begin
					if (bit_nz) begin
						rnz_r <= 1'b1;
					end
					// (RL2) first bit lands lowest
					if (ridx_r != 4'h0 && ridx_r != nbits - 4'h1) begin
						rxsh_r <= {vote, rxsh_r[8:1]};
					end
					if (fr_end) begin
						rx_st_r <= RX_IDLE;
						rx_prev_r <= vote;
					end
				end
				if (rt_r == `SCI_OVERSAMPLE) begin
					ridx_r <= ridx_r + 4'h1;
				end
			end
			default: rx_st_r <= RX_IDLE;
			endcase
		end
	end

	// registers and flags; a hardware set beats a software clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctl1_r <= `SCI_RST_CTL;
			ctl2_r <= `SCI_RST_CTL;
			rate_r <= `SCI_RST_RATE;
			tdr_r <= 8'h00;
			rdr_r <= 8'h00;
			rx8_r <= 1'b0;
			tx_buffer_empty_r <= 1'b1;
			tc_r <= 1'b1;
			rbf_r <= 1'b0;
			idle_r <= 1'b0;
			ovr_r <= 1'b0;
			nf_r <= 1'b0;
			fe_r <= 1'b0;
			got_char_r <= 1'b0;
		end else begin
			// (RL18) control fields
			if (wr_en && awaddr_q_r == `SCI_OFS_CTL1) begin
				ctl1_r <= wdata_q_r;
			end
			// (RL17) rates written any time
			if (wr_en && awaddr_q_r == `SCI_OFS_RATE) begin
				rate_r <= wdata_q_r;
			end
			// (RL21) wake clears sleep
			if (wake_adr | wake_idl) begin
				ctl2_r <= {ctl2_r[7:2], 1'b0, ctl2_r[0]};
			end else if (wr_en && awaddr_q_r == `SCI_OFS_CTL2) begin
				ctl2_r <= wdata_q_r;
			end
			// (RL6) data write loads the holding byte
			if (wr_data) begin
				tdr_r <= wdata_q_r;
			end
			// (RL7) move to shifter empties buffer
			if (ld_dat) begin
				tx_buffer_empty_r <= 1'b1;
			end else if (wr_data) begin
				tx_buffer_empty_r <= 1'b0;
			end
			// (RL8) (RL9) drained with nothing pending
			if (tx_end) begin
				tc_r <= 1'b1;
			// a load also clears, so a byte written as the
			// shifter drains cannot leave the flag standing
			end else if (wr_data || ld_dat || ld_pre || ld_brk ||
				(wr_flag && wdata_q_r[`SCI_F_TC])) begin
				tc_r <= 1'b0;
			end
			// (RL11) (RL19) move byte unless asleep, but an address-mark wake byte is moved
			if (rx_live & ~rbf_r) begin
				rdr_r <= rx_byte;
				rx8_r <= rxsh_r[8];
				rbf_r <= 1'b1;
			end else if (rd_data || (wr_flag && wdata_q_r[`SCI_F_RBF])) begin
				rbf_r <= 1'b0;
			end
			// (RL12) overrun keeps the older byte
			if (rx_live & rbf_r) begin
				ovr_r <= 1'b1;
			end else if (wr_flag && wdata_q_r[`SCI_F_OVR]) begin
				ovr_r <= 1'b0;
			end
			// stop-bit noise is voted in the same tick, so use it direct
			if (rx_live & (rnz_r | bit_nz)) begin
				nf_r <= 1'b1;
			end else if (wr_flag && wdata_q_r[`SCI_F_NOISE]) begin
				nf_r <= 1'b0;
			end
			// (RL4) stop low: framing or break
			if (rx_live & ~vote) begin
				fe_r <= 1'b1;
			end else if (wr_flag && wdata_q_r[`SCI_F_FRM]) begin
				fe_r <= 1'b0;
			end
			// (RL14) idle armed by a character
			if (rx_live & vote) begin
				got_char_r <= 1'b1;
			end else if (idle_set) begin
				got_char_r <= 1'b0;
			end
			if (idle_set) begin
				idle_r <= 1'b1;
			end else if (wr_flag && wdata_q_r[`SCI_F_IDLE]) begin
				idle_r <= 1'b0;
			end
		end
	end

	// (RL13) interrupt request
	always @(posedge aclk) begin
		if (!aresetn) begin
			sci_irq <= 1'b0;
		end else begin
			sci_irq <= (tx_buffer_empty_r & ctl2_r[`SCI_C2_TXIE]) |
				(tc_r & ctl2_r[`SCI_C2_TX_DONE_IRQ_EN]) |
				((rbf_r | ovr_r) & ctl2_r[`SCI_C2_RXIE]) |
				(idle_r & ctl2_r[`SCI_C2_ILIE]);
		end
	end
	// (RL22) both directions run concurrently above
endmodule // sci_top
`default_nettype wire

/* verification/sci_chk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the bus handshakes and the transmit pin
module sci_chk (
	input wire logic aclk, // bus clock
	input wire logic aresetn, // reset, low
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp, // read response
	input wire logic s_axi_rvalid, // r valid
	input wire logic tx_line, // transmit pin
	input wire logic tx_line_oe, // transmit enable
	input wire logic sclk_oe // shift clock enable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_idle_high;
		!tx_line_oe |-> tx_line;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("tx line low while released");
	// a low bit lasts at least eight clocks at any rate
	property p_start_len;
		$fell(tx_line) |-> (!tx_line)[*8];
	endproperty
	a_start_len: assert property (p_start_len)
		else $error("low bit shorter than a bit time");
	property p_fall_driven;
		$fell(tx_line) |-> tx_line_oe;
	endproperty
	a_fall_driven: assert property (p_fall_driven)
		else $error("frame sent without pin drive");
	property p_oe_pair;
		sclk_oe == tx_line_oe;
	endproperty
	a_oe_pair: assert property (p_oe_pair)
		else $error("shift clock enable differs from tx enable");
	property p_b_after_w;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:2] s_axi_bvalid;
	endproperty
	a_b_after_w: assert property (p_b_after_w)
		else $error("write response late");
	property p_aw_quiet;
		s_axi_awvalid && s_axi_awready |=> (!s_axi_awready)[*2];
	endproperty
	a_aw_quiet: assert property (p_aw_quiet)
		else $error("write address taken twice");
	property p_r_after_ar;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_after_ar: assert property (p_r_after_ar)
		else $error("read data late");
	property p_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
			|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not refused");
endmodule // sci_chk
bind sci_top sci_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .tx_line, .tx_line_oe, .sclk_oe);
`default_nettype wire

/* verification/sci_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// remote transceiver at the fastest rate setting
module sci_peer (
	input wire logic aclk, // bench clock
	input wire logic line_in, // level of the block's tx pin
	output logic line_out, // drives the block's rx pin
	output logic [7:0] got_byte, // last character caught
	output logic [7:0] got_cnt // characters caught
);
	localparam int BIT = 16; // clocks per bit at rate zero
	logic [7:0] sh; // receive shifter
	logic [9:0] fr; // frame being sent
	initial begin
		line_out = 1'b1;
		got_cnt = 8'h00;
		got_byte = 8'h00;
	end
	task automatic send(input logic [7:0] d, input logic stop);
		begin
			fr = {stop, d, 1'b0};
			for (int i = 0; i < 10; i++) begin
				line_out <= fr[i];
				repeat (BIT) @(posedge aclk);
			end
			line_out <= 1'b1;
		end
	endtask
	// catch mid-bit; a bad stop drops the frame
	always begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge aclk);
			sh[i] = line_in;
		end
		repeat (BIT) @(posedge aclk);
		if (line_in === 1'b1) begin
			got_byte <= sh;
			got_cnt <= got_cnt + 8'h01;
		end
	end
endmodule // sci_peer
`default_nettype wire

/* verification/serial_comm_interface_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sci_consts.vh"
module serial_comm_interface_tb;
	logic aclk = 1'b0; // 250 MHz
	logic aresetn = 1'b0; // reset, low
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, rx_line, tx_line, tx_line_oe, sclk_o, sclk_oe;
	logic sci_irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
	logic [31:0] s_axi_rdata, rd_d;
	logic [7:0] got_byte, got_cnt;
	logic tx_wire; // released pin is pulled high
	int n_fail = 0, samples_checked = 0, cyc = 0, n, n_clk = 0;
	assign tx_wire = tx_line_oe ? tx_line : 1'b1;
	always #2 aclk = ~aclk;
	// shift clock pulses seen on the pin
	always @(posedge sclk_o) n_clk++;
	sci_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_line, .tx_line,
		.tx_line_oe, .sclk_o, .sclk_oe, .sci_irq);
	sci_peer u_peer (.aclk, .line_in(tx_wire), .line_out(rx_line),
		.got_byte, .got_cnt);
	task automatic close_out;
		begin
			$display("checks %0d mismatches %0d", samples_checked, n_fail);
			if (n_fail == 0 && samples_checked > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask
	// a hang counts as a mismatch
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			close_out;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		begin
			samples_checked++;
			if (g !== e) begin
				n_fail++;
				$display("[ERR] %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// each channel held until its own ready
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h000000, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
				if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			end while (s_axi_bvalid !== 1'b1);
			wr_r = s_axi_bresp;
			s_axi_bready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	task automatic rd(input logic [7:0] a);
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			end while (s_axi_rvalid !== 1'b1);
			rd_d = s_axi_rdata;
			rd_r = s_axi_rresp;
			s_axi_rready <= 1'b0;
			@(posedge aclk);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string nm);
		begin
			rd(a);
			chk(nm, e, rd_d & m);
		end
	endtask
	// poll a status bit under a bound, then expect it set
	task automatic fwait(input string nm, input int b);
		begin
			n = 0;
			do begin
				rd(`SCI_OFS_FLAG);
				n++;
			end while (rd_d[b] !== 1'b1 && n < 300);
			chk(nm, 32'h1, {31'h0, rd_d[b]});
		end
	endtask
	task automatic wait_got(input logic [7:0] k);
		begin
			n = 0;
			while (got_cnt !== k && n < 2000) begin
				@(posedge aclk);
				n++;
			end
		end
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(`SCI_OFS_FLAG, 32'hFE, 32'hC0, "flags at reset");
		rchk(`SCI_OFS_CTL2, 32'hFF, 32'h00, "ctl_two at reset");
		rchk(`SCI_OFS_RATE, 32'hFF, 32'h00, "rate at reset");
		rd(8'h14);
		chk("unmapped resp", 32'h2, {30'h0, rd_r});
		wr(8'h14, 8'h00);
		chk("unmapped write", 32'h2, {30'h0, wr_r});
		// rates set only while both directions are off
		wr(`SCI_OFS_RATE, 8'h00);
		// two bytes back to back behind the preamble
		wr(`SCI_OFS_CTL2, 8'h0C);
		wr(`SCI_OFS_DATA, 8'hA5);
		rchk(`SCI_OFS_FLAG, 32'hC0, 32'h00, "tx buffer held");
		fwait("tx buffer moved", `SCI_F_TX_BUFFER_EMPTY);
		wr(`SCI_OFS_DATA, 8'h3C);
		wait_got(8'h01);
		chk("tx byte one", 32'hA5, {24'h0, got_byte});
		wait_got(8'h02);
		chk("tx byte two", 32'h3C, {24'h0, got_byte});
		fwait("tx done", `SCI_F_TC);
		// receive path
		u_peer.send(8'h96, 1'b1);
		fwait("rx full", `SCI_F_RBF);
		rchk(`SCI_OFS_DATA, 32'hFF, 32'h96, "rx byte");
		rchk(`SCI_OFS_FLAG, 32'h2E, 32'h00, "rx clean");
		fwait("idle after char", `SCI_F_IDLE);
		u_peer.send(8'h55, 1'b0);
		fwait("framing error", `SCI_F_FRM);
		rd(`SCI_OFS_DATA);
		wr(`SCI_OFS_FLAG, 8'hFF);
		// sleeping receiver, address-mark wake
		wr(`SCI_OFS_CTL1, 8'h08);
		wr(`SCI_OFS_CTL2, 8'h0E);
		u_peer.send(8'h12, 1'b1);
		repeat (200) @(posedge aclk);
		rchk(`SCI_OFS_FLAG, 32'h3E, 32'h00, "flags asleep");
		rchk(`SCI_OFS_CTL2, 32'hFF, 32'h0E, "still asleep");
		u_peer.send(8'h92, 1'b1);
		repeat (40) @(posedge aclk);
		rchk(`SCI_OFS_CTL2, 32'hFF, 32'h0C, "woken");
		// second byte while the first is unread
		u_peer.send(8'h33, 1'b1);
		fwait("overrun", `SCI_F_OVR);
		rchk(`SCI_OFS_DATA, 32'hFF, 32'h92, "older byte kept");
		// disable in mid character
		wr(`SCI_OFS_DATA, 8'h0F);
		n = 0;
		while (tx_wire !== 1'b0 && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		wr(`SCI_OFS_CTL2, 8'h04);
		wait_got(8'h03);
		chk("char finished", 32'h0F, {24'h0, got_byte});
		// three data frames, seven clocks each without last-bit clock
		chk("shift clocks", 32'h15, n_clk);
		fwait("done when off", `SCI_F_TC);
		repeat (20) @(posedge aclk);
		chk("pin released", 32'h0, {31'h0, tx_line_oe});
		chk("irq masked", 32'h0, {31'h0, sci_irq});
		wr(`SCI_OFS_CTL2, 8'h44);
		chk("irq tx done", 32'h1, {31'h0, sci_irq});
		close_out;
	end
endmodule // serial_comm_interface_tb
`default_nettype wire
